// file: hw/kmi_top.sv
// keypad decoding, three-level parameter menu and status indicators
// assumes the parameter store answers value and flags combinationally for
// the group and index shown on param_group_out / param_index_out
//
// Notes on behaviour
// - source light: keypad off, terminal on, link flashes
// - direction light: forward off, reverse on
// - alarm: torque on, tuning 1 Hz, fault 4 Hz
// - menu key enters or leaves first level
// - confirm descends levels, accepts at value level
// - up increases, down decreases selected item
// - shift cycles monitors, or moves edit digit
// - run key works only under keypad source
// - stop key stops; scope set by parameter
// - stop key resets fault in fault state
// - multi key toggles function chosen by parameter
// - three levels: group, parameter, setting value
// - edits accepted only while digit flashes
// - confirm stores, returns, selects next parameter
// - menu at value discards, keeps same parameter
// - locked parameter shows no flash, ignores edits
// - read-only parameters never editable from keypad
// - stop-only parameters locked while running
`timescale 1ns/1ps
`default_nettype none
module kmi_top #(
    parameter int         TICK_CYCLES = kmi_pkg::TICK_CYCLES,
    parameter logic [6:0] GROUP_LAST  = kmi_pkg::GROUP_LAST_DEF,
    parameter logic [6:0] PARAM_LAST  = kmi_pkg::PARAM_LAST_DEF,
    parameter logic [6:0] MON_LAST    = kmi_pkg::MON_LAST_DEF
) (
    input  wire logic                          clk_in,
    input  wire logic                          reset_n_in,
    input  wire logic [kmi_pkg::KEY_COUNT-1:0] keys_in,
    input  wire logic [1:0]                    cmd_source_in,
    input  wire logic                          running_in,
    input  wire logic                          reverse_in,
    input  wire logic                          torque_mode_in,
    input  wire logic                          tuning_in,
    input  wire logic                          fault_in,
    input  wire logic                          stop_key_scope_param_in,
    input  wire logic [3:0]                    multi_key_function_param_in,
    input  wire logic [15:0]                   param_value_in,
    input  wire logic                          param_read_only_in,
    input  wire logic                          param_stop_only_in,
    output logic                               command_source_indicator_out,
    output logic                               direction_indicator_out,
    output logic                               alarm_indicator_out,
    output logic [1:0]                         menu_level_out,
    output logic [4:0]                         param_group_out,
    output logic [6:0]                         param_index_out,
    output logic [15:0]                        edit_value_out,
    output logic [1:0]                         edit_digit_out,
    output logic                               digit_flash_out,
    output logic [3:0]                         monitor_select_out,
    output logic                               store_strobe_out,
    output logic [6:0]                         store_index_out,
    output logic                               run_request_out,
    output logic                               stop_request_out,
    output logic                               fault_reset_request_out,
    output logic                               multi_key_event_out,
    output logic                               multi_key_toggle_out,
    output logic [3:0]                         multi_key_action_out
);
    localparam int TICK_W = $clog2(TICK_CYCLES);

    typedef struct packed {
        kmi_pkg::kmi_level_t          lvl;
        logic [4:0]                   group;
        logic [6:0]                   index;
        logic [15:0]                  value;
        logic [1:0]                   digit;
        logic                         flash;
        logic                         store;
        logic [6:0]                   st_index;
        logic [3:0]                   mon;
        logic [TICK_W-1:0]            tick_cnt;
        logic                         tick;
        logic [kmi_pkg::SLOW_W-1:0]   slow_cnt;
        logic [kmi_pkg::FAST_W-1:0]   fast_cnt;
        logic                         slow_ph;
        logic                         fast_ph;
        logic                         cmd_led;
        logic                         dir_led;
        logic                         alm_led;
        logic                         run_req;
        logic                         stop_req;
        logic                         rst_req;
        logic                         mf_evt;
        logic                         mf_toggle;
        logic [3:0]                   mf_action;
    } kmi_state_t;

    kmi_state_t                  s;
    kmi_state_t                  next_s;
    logic [1:0]                  rst_sync;
    logic                        rst_n;
    logic [kmi_pkg::KEY_COUNT-1:0] press;
    logic                        editable;
    logic                        up_ok;
    logic                        dn_ok;
    logic                        sh_ok;

    // release the reset through two flops so every flop leaves reset together
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    kmi_debounce #(
        .KEYS    (kmi_pkg::KEY_COUNT),
        .SAMPLES (kmi_pkg::DEBOUNCE_SAMPLES)
    ) u_debounce (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n),
        .tick_in   (s.tick),
        .keys_in   (keys_in),
        .press_out (press)
    );

    // flags follow the selected parameter live, so a stop-only item unlocks
    // as soon as the drive stops without leaving the value level
    assign editable = !param_read_only_in && !(param_stop_only_in && running_in);
    assign up_ok    = press[kmi_pkg::KEY_UP] && s.flash;
    assign dn_ok    = press[kmi_pkg::KEY_DOWN] && s.flash;
    assign sh_ok    = press[kmi_pkg::KEY_SHIFT] && s.flash;

    always_comb
    begin
        next_s          = s;
        next_s.store    = 1'b0;
        next_s.run_req  = 1'b0;
        next_s.stop_req = 1'b0;
        next_s.rst_req  = 1'b0;
        next_s.mf_evt   = 1'b0;
        next_s.tick     = 1'b0;

        // 1 ms tick and the two blink phases
        if (s.tick_cnt == TICK_W'(TICK_CYCLES - 1))
        begin
            next_s.tick_cnt = '0;
            next_s.tick     = 1'b1;
        end
        else
        begin
            next_s.tick_cnt = TICK_W'(s.tick_cnt + 1'b1);
        end
        if (s.tick)
        begin
            if (s.slow_cnt == kmi_pkg::SLOW_W'(kmi_pkg::SLOW_HALF_MS - 1))
            begin
                next_s.slow_cnt = '0;
                next_s.slow_ph  = !s.slow_ph;
            end
            else
            begin
                next_s.slow_cnt = kmi_pkg::SLOW_W'(s.slow_cnt + 1'b1);
            end
            if (s.fast_cnt == kmi_pkg::FAST_W'(kmi_pkg::FAST_HALF_MS - 1))
            begin
                next_s.fast_cnt = '0;
                next_s.fast_ph  = !s.fast_ph;
            end
            else
            begin
                next_s.fast_cnt = kmi_pkg::FAST_W'(s.fast_cnt + 1'b1);
            end
        end

        // indicators
        next_s.cmd_led = (cmd_source_in == kmi_pkg::SRC_TERMINAL)
                      || ((cmd_source_in == kmi_pkg::SRC_COMM) && s.slow_ph);
        next_s.dir_led = reverse_in;
        if (fault_in)
            next_s.alm_led = s.fast_ph;
        else if (tuning_in)
            next_s.alm_led = s.slow_ph;
        else
            next_s.alm_led = torque_mode_in;

        // operation keys
        if (press[kmi_pkg::KEY_RUN] && (cmd_source_in == kmi_pkg::SRC_KEYPAD) && !fault_in)
            next_s.run_req = 1'b1;
        if (press[kmi_pkg::KEY_STOP])
        begin
            if (fault_in)
                next_s.rst_req = 1'b1;
            else if (running_in
                     && (stop_key_scope_param_in || (cmd_source_in == kmi_pkg::SRC_KEYPAD)))
                next_s.stop_req = 1'b1;
        end
        if (press[kmi_pkg::KEY_MULTI])
        begin
            next_s.mf_evt    = 1'b1;
            next_s.mf_toggle = !s.mf_toggle;
            next_s.mf_action = multi_key_function_param_in;
        end

        // menu walk
        case (s.lvl)
            kmi_pkg::KMI_LVL_DISPLAY:
            begin
                if (press[kmi_pkg::KEY_MENU] || press[kmi_pkg::KEY_CONFIRM])
                    next_s.lvl = kmi_pkg::KMI_LVL_GROUP;
                else if (press[kmi_pkg::KEY_SHIFT])
                    next_s.mon = 4'(kmi_pkg::kmi_wrap({3'h0, s.mon}, MON_LAST, 1'b1));
            end
            kmi_pkg::KMI_LVL_GROUP:
            begin
                if (press[kmi_pkg::KEY_MENU])
                    next_s.lvl = kmi_pkg::KMI_LVL_DISPLAY;
                else if (press[kmi_pkg::KEY_CONFIRM])
                begin
                    next_s.lvl   = kmi_pkg::KMI_LVL_PARAM;
                    next_s.index = 7'h00;
                end
                else if (up_ok || dn_ok)
                    next_s.group = 5'(kmi_pkg::kmi_wrap({2'h0, s.group}, GROUP_LAST, up_ok));
            end
            kmi_pkg::KMI_LVL_PARAM:
            begin
                if (press[kmi_pkg::KEY_MENU])
                    next_s.lvl = kmi_pkg::KMI_LVL_GROUP;
                else if (press[kmi_pkg::KEY_CONFIRM])
                begin
                    next_s.lvl   = kmi_pkg::KMI_LVL_VALUE;
                    next_s.value = param_value_in;
                    next_s.digit = 2'h0;
                end
                else if (up_ok || dn_ok)
                    next_s.index = kmi_pkg::kmi_wrap(s.index, PARAM_LAST, up_ok);
            end
            kmi_pkg::KMI_LVL_VALUE:
            begin
                if (press[kmi_pkg::KEY_MENU])
                    next_s.lvl = kmi_pkg::KMI_LVL_PARAM;
                else if (press[kmi_pkg::KEY_CONFIRM])
                begin
                    // a locked item is left unchanged: no store, still advance
                    next_s.lvl      = kmi_pkg::KMI_LVL_PARAM;
                    next_s.store    = s.flash;
                    next_s.st_index = s.index;
                    next_s.index    = kmi_pkg::kmi_wrap(s.index, PARAM_LAST, 1'b1);
                end
                else if (up_ok)
                    next_s.value = 16'(s.value + kmi_pkg::kmi_digit_step(s.digit));
                else if (dn_ok)
                    next_s.value = 16'(s.value - kmi_pkg::kmi_digit_step(s.digit));
                else if (sh_ok)
                    next_s.digit = (s.digit == kmi_pkg::DIGIT_LAST) ? 2'h0
                                   : 2'(s.digit + 2'h1);
            end
            default:
                next_s.lvl = kmi_pkg::KMI_LVL_DISPLAY;
        endcase

        // flash marks what the edit keys may change
        if (next_s.lvl == kmi_pkg::KMI_LVL_VALUE)
            next_s.flash = editable;
        else
            next_s.flash = (next_s.lvl != kmi_pkg::KMI_LVL_DISPLAY);
    end

    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end

    assign command_source_indicator_out = s.cmd_led;
    assign direction_indicator_out      = s.dir_led;
    assign alarm_indicator_out          = s.alm_led;
    assign menu_level_out               = s.lvl;
    assign param_group_out              = s.group;
    assign param_index_out              = s.index;
    assign edit_value_out               = s.value;
    assign edit_digit_out               = s.digit;
    assign digit_flash_out              = s.flash;
    assign monitor_select_out           = s.mon;
    assign store_strobe_out             = s.store;
    assign store_index_out              = s.st_index;
    assign run_request_out              = s.run_req;
    assign stop_request_out             = s.stop_req;
    assign fault_reset_request_out      = s.rst_req;
    assign multi_key_event_out          = s.mf_evt;
    assign multi_key_toggle_out         = s.mf_toggle;
    assign multi_key_action_out         = s.mf_action;

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    a_cmd_keypad_dark: assert property ($past(cmd_source_in) == kmi_pkg::SRC_KEYPAD
        |-> !command_source_indicator_out) else $error("source light lit under keypad");
    a_dir_follows: assert property (##1 direction_indicator_out == $past(reverse_in))
        else $error("direction light wrong");
    a_alarm_fast: assert property ($past(fault_in) |-> alarm_indicator_out == $past(s.fast_ph))
        else $error("alarm not fast flashing in fault");
    a_run_gate: assert property (run_request_out |-> $past(cmd_source_in) == kmi_pkg::SRC_KEYPAD
        && $past(press[kmi_pkg::KEY_RUN])) else $error("run request without keypad source");
    a_stop_fault: assert property (press[kmi_pkg::KEY_STOP] && fault_in
        |=> fault_reset_request_out && !stop_request_out) else $error("stop not reset in fault");
    a_stop_run: assert property (stop_request_out |-> $past(running_in) && !$past(fault_in))
        else $error("stop request while not running");
    a_confirm_store: assert property (s.lvl == kmi_pkg::KMI_LVL_VALUE && s.flash
        && press[kmi_pkg::KEY_CONFIRM] |=> store_strobe_out && store_index_out == $past(s.index)
        && menu_level_out == kmi_pkg::KMI_LVL_PARAM) else $error("confirm did not store");
    a_menu_discard: assert property (s.lvl == kmi_pkg::KMI_LVL_VALUE && press[kmi_pkg::KEY_MENU]
        |=> !store_strobe_out && param_index_out == $past(s.index)
        && menu_level_out == kmi_pkg::KMI_LVL_PARAM) else $error("menu did not discard");
    a_locked_value: assert property (s.lvl == kmi_pkg::KMI_LVL_VALUE && !s.flash
        |=> $stable(edit_value_out) && $stable(edit_digit_out)) else $error("locked value changed");
    a_stop_only_lock: assert property (s.lvl == kmi_pkg::KMI_LVL_VALUE
        && next_s.lvl == kmi_pkg::KMI_LVL_VALUE && param_stop_only_in && running_in
        |=> !digit_flash_out) else $error("stop-only item editable while running");
    a_one_event: assert property (press[kmi_pkg::KEY_UP] |=> !press[kmi_pkg::KEY_UP])
        else $error("key event longer than one cycle");

    c_store: cover property (store_strobe_out);
    c_fault_reset: cover property (fault_reset_request_out);
    c_value_edit: cover property (s.lvl == kmi_pkg::KMI_LVL_VALUE && up_ok);
endmodule // kmi_top
`default_nettype wire

// file: hw/kmi_pkg.sv
// constants, level encoding and shared helpers for the keypad menu indicator block
// assumes a single 50 MHz system clock; all counts derive from it
`default_nettype none
package kmi_pkg;
    // clock and time base
    localparam int CLK_PERIOD_NS   = 20;
    localparam int TICK_NS         = 1_000_000;
    localparam int TICK_CYCLES     = TICK_NS / CLK_PERIOD_NS;
    localparam int SLOW_HALF_MS    = 500;
    localparam int FAST_HALF_MS    = 125;
    localparam int SLOW_W          = 10;
    localparam int FAST_W          = 8;
    localparam int DEBOUNCE_SAMPLES = 8;

    // key bit positions on the key input bus
    localparam int KEY_MENU    = 0;
    localparam int KEY_CONFIRM = 1;
    localparam int KEY_UP      = 2;
    localparam int KEY_DOWN    = 3;
    localparam int KEY_SHIFT   = 4;
    localparam int KEY_RUN     = 5;
    localparam int KEY_STOP    = 6;
    localparam int KEY_MULTI   = 7;
    localparam int KEY_COUNT   = 8;

    // command source encoding
    localparam logic [1:0] SRC_KEYPAD   = 2'h0;
    localparam logic [1:0] SRC_TERMINAL = 2'h1;
    localparam logic [1:0] SRC_COMM     = 2'h2;

    // menu walk limits
    localparam logic [6:0] GROUP_LAST_DEF = 7'h1F;
    localparam logic [6:0] PARAM_LAST_DEF = 7'h63;
    localparam logic [6:0] MON_LAST_DEF   = 7'h0F;
    localparam logic [1:0] DIGIT_LAST     = 2'h3;

    // gray along display, group, parameter, value
    typedef enum logic [1:0] {
        KMI_LVL_DISPLAY = 2'h0,
        KMI_LVL_GROUP   = 2'h1,
        KMI_LVL_PARAM   = 2'h3,
        KMI_LVL_VALUE   = 2'h2
    } kmi_level_t;

    function automatic logic [6:0] kmi_wrap(input logic [6:0] cur,
                                           input logic [6:0] last,
                                           input logic       inc);
        if (inc)
            kmi_wrap = (cur >= last) ? 7'h00 : 7'(cur + 7'h01);
        else
            kmi_wrap = (cur == 7'h00) ? last : 7'(cur - 7'h01);
    endfunction

    // weight of the selected hex digit
    function automatic logic [15:0] kmi_digit_step(input logic [1:0] digit);
        kmi_digit_step = 16'(16'h0001 << {digit, 2'h0});
    endfunction
endpackage
`default_nettype wire

// file: hw/kmi_debounce.sv
// key debouncer: one press pulse per physical press
// assumes keys are active high, synchronous, and tick_in is a one-cycle enable
`timescale 1ns/1ps
`default_nettype none
module kmi_debounce #(
    parameter int KEYS    = kmi_pkg::KEY_COUNT,
    parameter int SAMPLES = kmi_pkg::DEBOUNCE_SAMPLES
) (
    input  wire logic            clk_in,
    input  wire logic            rst_n_in,
    input  wire logic            tick_in,
    input  wire logic [KEYS-1:0] keys_in,
    output logic      [KEYS-1:0] press_out
);
    typedef struct packed {
        logic [KEYS-1:0][SAMPLES-1:0] hist;
        logic [KEYS-1:0]              level;
        logic [KEYS-1:0]              press;
    } kmi_deb_t;

    kmi_deb_t s;
    kmi_deb_t next_s;

    // a level only flips after a full run of equal samples, so a bouncing
    // contact never makes a second edge; holding the key gives no repeats
    always_comb
    begin
        next_s       = s;
        next_s.press = '0;
        if (tick_in)
        begin
            for (int k = 0; k < KEYS; k++)
            begin
                next_s.hist[k] = {s.hist[k][SAMPLES-2:0], keys_in[k]};
                if (&next_s.hist[k] && !s.level[k])
                begin
                    next_s.level[k] = 1'b1;
                    next_s.press[k] = 1'b1;
                end
                else if (~|next_s.hist[k])
                begin
                    next_s.level[k] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            s <= '0;
        else
            s <= next_s;
    end

    assign press_out = s.press;
endmodule // kmi_debounce
`default_nettype wire

// file: verif/kmi_operator.sv
// operator model: presses and releases single keypad keys
// assumes the keypad samples on a tick every TICK clocks and settles after eight samples
`timescale 1ns/1ps
`default_nettype none
module kmi_operator #(
    parameter int TICK = 4
) (
    input  wire logic                          clk_in,
    output logic [kmi_pkg::KEY_COUNT-1:0]      keys_out
);
    initial keys_out = '0;

    // contact chatter first, then a hold and a release both well past eight samples
    task automatic press(input int key);
        repeat (3)
        begin
            @(posedge clk_in) keys_out[key] <= 1'b1;
            @(posedge clk_in) keys_out[key] <= 1'b0;
        end
        @(posedge clk_in) keys_out[key] <= 1'b1;
        repeat (12 * TICK) @(posedge clk_in);
        keys_out[key] <= 1'b0;
        repeat (12 * TICK) @(posedge clk_in);
    endtask
endmodule // kmi_operator
`default_nettype wire

// file: verif/tb.sv
// keypad bench: operator presses keys, every request pulse is matched to a note
// assumes kmi_top with a 4-clock tick, so a debounce takes 32 clocks
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int TICK = 4;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [kmi_pkg::KEY_COUNT-1:0] keys;
    logic [1:0] src = 2'h0;
    logic running = 1'b0, reverse = 1'b0, torque = 1'b0, tuning = 1'b0, fault = 1'b0;
    logic scope = 1'b0, ro = 1'b0, so = 1'b0;
    logic [3:0] mparam = 4'h0;
    logic [15:0] pval = 16'h0000;
    logic cmd_led, dir_led, alm_led, flash, stb, runq, stopq, frq, mke, mkt;
    logic [1:0] lvl, dig;
    logic [4:0] grp;
    logic [6:0] idx, sidx;
    logic [15:0] ev;
    logic [3:0] mon, mka;
    logic [31:0] rng = 32'hf864_4d22;
    logic [27:0] notes[$];
    int err_total = 0;
    int tests_run = 0;
    wire logic [27:0] seen = {stb, runq, stopq, frq, mke, stb ? {sidx, ev} : 23'h00_0000};

    always #10 clk_in = ~clk_in;

    kmi_operator #(.TICK(TICK)) op (.clk_in(clk_in), .keys_out(keys));

    kmi_top #(.TICK_CYCLES(TICK)) DUT (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .keys_in(keys), .cmd_source_in(src),
        .running_in(running), .reverse_in(reverse), .torque_mode_in(torque),
        .tuning_in(tuning), .fault_in(fault), .stop_key_scope_param_in(scope),
        .multi_key_function_param_in(mparam), .param_value_in(pval),
        .param_read_only_in(ro), .param_stop_only_in(so),
        .command_source_indicator_out(cmd_led), .direction_indicator_out(dir_led),
        .alarm_indicator_out(alm_led), .menu_level_out(lvl), .param_group_out(grp),
        .param_index_out(idx), .edit_value_out(ev), .edit_digit_out(dig),
        .digit_flash_out(flash), .monitor_select_out(mon), .store_strobe_out(stb),
        .store_index_out(sidx), .run_request_out(runq), .stop_request_out(stopq),
        .fault_reset_request_out(frq), .multi_key_event_out(mke),
        .multi_key_toggle_out(mkt), .multi_key_action_out(mka));

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one note per pulse: a second pulse from a single press finds no note
    always @(negedge clk_in)
        if (reset_n_in && (stb | runq | stopq | frq | mke))
            chk("pulse", 32'(seen), notes.size() ? 32'(notes.pop_front()) : 32'h0);

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic hit(input int key);
        op.press(key);
        @(negedge clk_in);
    endtask

    // slow flash halves are 2000 clocks and fast ones 500 at this tick
    task automatic lights(input int ec, input int ea, input logic lc, input logic la);
        int nc;
        int na;
        logic pc;
        logic pa;
        nc = 0;
        na = 0;
        cyc(3);
        @(negedge clk_in);
        pc = cmd_led;
        pa = alm_led;
        repeat (4000)
        begin
            @(negedge clk_in);
            nc += int'(cmd_led !== pc);
            na += int'(alm_led !== pa);
            pc = cmd_led;
            pa = alm_led;
        end
        chk("source flashes", nc, ec);
        chk("alarm flashes", na, ea);
        if (ec == 0) chk("source light", 32'(cmd_led), 32'(lc));
        if (ea == 0) chk("alarm light", 32'(alm_led), 32'(la));
        @(posedge clk_in);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        cyc(4);
        reset_n_in <= 1'b1;
        cyc(4);
        @(negedge clk_in);
        chk("reset state", 32'({lvl, flash, stb, cmd_led, alm_led}), 32'h0);
        lights(0, 0, 1'b0, 1'b0);
        src <= 2'h1;
        torque <= 1'b1;
        lights(0, 0, 1'b1, 1'b1);
        src <= 2'h2;
        tuning <= 1'b1;
        lights(2, 2, 1'b0, 1'b0);
        fault <= 1'b1;
        lights(2, 8, 1'b0, 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk_in);
            reverse <= i[0];
            cyc(3);
            @(negedge clk_in);
            chk("direction light", 32'(dir_led), 32'(i));
        end
        @(posedge clk_in);
        {src, torque, tuning, fault, reverse} <= 6'h00;
        $display("test lights done");
        hit(kmi_pkg::KEY_MENU);
        chk("group level", 32'({lvl, flash}), 32'h3);
        hit(kmi_pkg::KEY_DOWN);
        chk("group wrap", 32'(grp), 32'(kmi_pkg::GROUP_LAST_DEF));
        hit(kmi_pkg::KEY_CONFIRM);
        chk("param level", 32'({lvl, idx}), 32'h180);
        hit(kmi_pkg::KEY_UP);
        chk("index", 32'(idx), 32'h1);
        rng = xs(rng);
        @(posedge clk_in);
        pval <= rng[15:0];
        hit(kmi_pkg::KEY_CONFIRM);
        chk("value level", 32'({lvl, ev}), 32'({2'h2, pval}));
        hit(kmi_pkg::KEY_UP);
        hit(kmi_pkg::KEY_SHIFT);
        chk("digit", 32'({dig, flash}), 32'h3);
        hit(kmi_pkg::KEY_DOWN);
        notes.push_back({5'h10, 7'h01, 16'(pval - 16'h000f)});
        hit(kmi_pkg::KEY_CONFIRM);
        chk("after store", 32'({lvl, idx}), 32'h182);
        hit(kmi_pkg::KEY_CONFIRM);
        hit(kmi_pkg::KEY_UP);
        hit(kmi_pkg::KEY_MENU);
        chk("after discard", 32'({lvl, idx}), 32'h182);
        @(posedge clk_in);
        ro <= 1'b1;
        hit(kmi_pkg::KEY_CONFIRM);
        hit(kmi_pkg::KEY_UP);
        chk("locked value", 32'({lvl, flash, ev}), 32'({3'h4, pval}));
        @(posedge clk_in);
        {ro, so, running} <= 3'h3;
        cyc(3);
        @(negedge clk_in);
        chk("flash running", 32'(flash), 32'h0);
        @(posedge clk_in);
        running <= 1'b0;
        cyc(3);
        @(negedge clk_in);
        chk("flash stopped", 32'(flash), 32'h1);
        @(posedge clk_in);
        so <= 1'b0;
        for (int i = 0; i < 3; i++) hit(kmi_pkg::KEY_MENU);
        chk("display level", 32'(lvl), 32'h0);
        hit(kmi_pkg::KEY_SHIFT);
        chk("monitor", 32'(mon), 32'h1);
        $display("test menu done");
        notes.push_back(28'h400_0000);
        hit(kmi_pkg::KEY_RUN);
        @(posedge clk_in);
        src <= 2'h1;
        hit(kmi_pkg::KEY_RUN);
        @(posedge clk_in);
        running <= 1'b1;
        hit(kmi_pkg::KEY_STOP);
        @(posedge clk_in);
        scope <= 1'b1;
        notes.push_back(28'h200_0000);
        hit(kmi_pkg::KEY_STOP);
        @(posedge clk_in);
        fault <= 1'b1;
        notes.push_back(28'h100_0000);
        hit(kmi_pkg::KEY_STOP);
        @(posedge clk_in);
        {fault, running, scope} <= 3'h0;
        for (int i = 0; i < 2; i++)
        begin
            rng = xs(rng);
            @(posedge clk_in);
            mparam <= rng[3:0];
            notes.push_back(28'h080_0000);
            hit(kmi_pkg::KEY_MULTI);
            chk("multi key", 32'({mkt, mka}), 32'({~i[0], mparam}));
        end
        for (int i = 0; i < 100 && notes.size() != 0; i++) @(posedge clk_in);
        chk("pending notes", 32'(notes.size()), 32'h0);
        $display("test requests done");
        complete_run();
    end
endmodule // tb
`default_nettype wire
